//--- internal_reset_cause_logic.sv
// reset cause logic: internal reset factors, cause status, reset pin as port
// assumes an apb master on pclk; factor inputs are on pclk, the reset pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_defs.svh"
module internal_reset_cause_logic #(
  parameter int TRIM_W = 6,
  parameter int HOLD_CYC = `RESET_HOLD_CYC,
  parameter int WARM_CYC = `WARMUP_CYC
) (
  // clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset factor sources
  input wire logic volt_detect,
  input wire logic wdt_overflow,
  input wire logic flash_standby,
  input wire logic flash_access,
  input wire logic trim_upset,
  // trimming storage
  input wire logic [TRIM_W-1:0] nvm_trim_data,
  input wire logic nvm_trim_par,
  output logic trim_fetch_req,
  output logic [TRIM_W-1:0] trim_value,
  // reset pin, shared with a port
  input wire logic reset_pin_in,
  output logic pin_is_port,
  output logic pin_port_value,
  // system reset and clock enables
  output logic cpu_reset_n,
  output logic [1:0] osc_enable
);

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic pin_s1_reg;
  logic pin_s2_reg;

  // pin idles high, so reset to one avoids a false external reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= reset_pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic ext_reset;
  assign ext_reset = !pin_is_port && !pin_s2_reg;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr_en;
  logic setup;
  logic access;
  logic hit_cause;
  logic hit_cfg;
  logic hit_key;
  logic hit_osc;
  logic hit_trim;
  logic mapped;
  assign setup = psel && !penable && !pready;
  // writes commit at the edge that completes the transfer, the same edge at which the master sees pready
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;
  assign hit_cause = paddr == `OFS_CAUSE;
  assign hit_cfg = paddr == `OFS_SYSCFG3;
  assign hit_key = paddr == `OFS_KEY;
  assign hit_osc = paddr == `OFS_OSC;
  assign hit_trim = paddr == `OFS_TRIM;
  assign mapped = hit_cause || hit_cfg || hit_key || hit_osc || hit_trim;

  logic key_pin_write;
  assign key_pin_write = wr_en && hit_key && pwdata[7:0] == `KEY_PIN;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  reset_cause_pkg::seq_state_type state_reg;
  logic [15:0] count_reg;
  logic [`CAUSE_FLAGS-1:0] flags_reg;
  logic [TRIM_W-1:0] trim_latch_reg;
  logic trim_par_reg;
  logic [1:0] osc_reg;
  logic trim_broken;
  logic osc_dead_write;
  logic [4:0] factor;

  assign trim_broken = ^{trim_latch_reg, trim_par_reg};
  assign osc_dead_write = wr_en && hit_osc && pwdata[1:0] == `OSC_DEAD;
  // factors only count while the cpu runs
  always_comb begin
    factor = 5'h00;
    if (state_reg == reset_cause_pkg::ST_RUN) begin
      factor[`BIT_VOLT] = volt_detect;
      factor[`BIT_WDT] = wdt_overflow;
      factor[`BIT_CLK] = osc_dead_write;
      factor[`BIT_TRIM_RST] = trim_broken;
      factor[`BIT_FLASH] = flash_standby && flash_access;
    end
  end

  // hold, then warm-up, then run; a low pin keeps the block in hold while it is not a port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= reset_cause_pkg::ST_HOLD;
      count_reg <= 16'h0000;
    end else if (ext_reset) begin
      state_reg <= reset_cause_pkg::ST_HOLD;
      count_reg <= 16'h0000;
    end else begin
      case (state_reg)
        reset_cause_pkg::ST_RUN: begin
          if (|factor) begin
            state_reg <= reset_cause_pkg::ST_HOLD;
            count_reg <= 16'h0000;
          end
        end
        reset_cause_pkg::ST_HOLD: begin
          if (count_reg == 16'(HOLD_CYC - 1)) begin
            state_reg <= reset_cause_pkg::ST_WARM;
            count_reg <= 16'h0000;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
        reset_cause_pkg::ST_WARM: begin
          if (count_reg == 16'(WARM_CYC - 1)) begin
            state_reg <= reset_cause_pkg::ST_RUN;
            count_reg <= 16'h0000;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= reset_cause_pkg::ST_HOLD;
          count_reg <= 16'h0000;
        end
      endcase
    end
  end

  logic warm_done;
  assign warm_done = state_reg == reset_cause_pkg::ST_WARM && count_reg == 16'(WARM_CYC - 1) && !ext_reset;

  // ----------------------------------------
  // trimming latch
  // ----------------------------------------
  // fetched at the last warm-up cycle; the upset input models noise hitting the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_latch_reg <= '0;
      trim_par_reg <= 1'b0;
    end else if (warm_done) begin
      trim_latch_reg <= nvm_trim_data;
      trim_par_reg <= nvm_trim_par;
    end else if (trim_upset && state_reg == reset_cause_pkg::ST_RUN) begin
      trim_latch_reg[0] <= !trim_latch_reg[0];
    end
  end

  // ----------------------------------------
  // cause status
  // ----------------------------------------
  logic clear_req_reg;

  // the clear request lives one cycle, then drops by itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_req_reg <= 1'b0;
    end else if (ext_reset) begin
      clear_req_reg <= 1'b0;
    end else begin
      clear_req_reg <= wr_en && hit_cause && pwdata[`BIT_CLEAR_REQ];
    end
  end

  // a factor set in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else if (ext_reset) begin
      flags_reg <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (factor[i]) begin
          flags_reg[i] <= 1'b1;
        end else if (clear_req_reg) begin
          flags_reg[i] <= 1'b0;
        end
      end
      if (warm_done && ^{nvm_trim_data, nvm_trim_par}) begin
        flags_reg[`BIT_TRIM_FAULT] <= 1'b1;
      end else if (clear_req_reg) begin
        flags_reg[`BIT_TRIM_FAULT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // reset pin function and oscillator enables
  // ----------------------------------------
  logic pin_disable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_disable_reg <= 1'b0;
    end else if (wr_en && hit_cfg) begin
      pin_disable_reg <= pwdata[`BIT_PIN_DISABLE];
    end
  end

  // only the key write moves the pin function, in either direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_is_port <= 1'b0;
    end else if (key_pin_write) begin
      pin_is_port <= pin_disable_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_port_value <= 1'b1;
    end else begin
      pin_port_value <= pin_is_port ? pin_s2_reg : 1'b1;
    end
  end

  // internal resets bring the oscillators back to their default; a dead pair is never stored,
  // so the enables cannot stop the clock even for the cycle before the reset takes over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_reg <= `OSC_RESET;
    end else if (state_reg == reset_cause_pkg::ST_HOLD) begin
      osc_reg <= `OSC_RESET;
    end else if (wr_en && hit_osc && pwdata[1:0] != `OSC_DEAD) begin
      osc_reg <= pwdata[1:0];
    end
  end
  assign osc_enable = osc_reg;

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_n <= 1'b0;
      trim_fetch_req <= 1'b0;
      trim_value <= '0;
    end else begin
      cpu_reset_n <= state_reg == reset_cause_pkg::ST_RUN && !(|factor) && !ext_reset;
      trim_fetch_req <= state_reg == reset_cause_pkg::ST_WARM && !ext_reset;
      trim_value <= trim_latch_reg;
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  logic [31:0] rd_mux;

  // the key register reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cause) begin
      rd_mux[`CAUSE_FLAGS-1:0] = flags_reg;
      rd_mux[`BIT_CLEAR_REQ] = clear_req_reg;
    end else if (hit_cfg) begin
      rd_mux[`BIT_PIN_DISABLE] = pin_disable_reg;
      rd_mux[`BIT_PIN_IS_PORT] = pin_is_port;
    end else if (hit_osc) begin
      rd_mux[1:0] = osc_reg;
    end else if (hit_trim) begin
      rd_mux[TRIM_W-1:0] = trim_latch_reg;
    end
  end

  // one wait-free access cycle: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // internal_reset_cause_logic
`default_nettype wire

//--- reset_cause_defs.svh
// offsets, field positions, reset values and timing counts of the reset cause block
// assumes inclusion by bare name from the top module, the checker and the bench
`ifndef RESET_CAUSE_DEFS_SVH
`define RESET_CAUSE_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CAUSE 12'h000
`define OFS_SYSCFG3 12'h004
`define OFS_KEY 12'h008
`define OFS_OSC 12'h00C
`define OFS_TRIM 12'h010
// ----------------------------------------
// cause register fields
// ----------------------------------------
`define BIT_VOLT 0
`define BIT_WDT 1
`define BIT_CLK 2
`define BIT_TRIM_RST 3
`define BIT_FLASH 4
`define BIT_TRIM_FAULT 5
`define BIT_CLEAR_REQ 7
`define CAUSE_FLAGS 6
// ----------------------------------------
// config fields, keys, reset values
// ----------------------------------------
`define BIT_PIN_DISABLE 0
`define BIT_PIN_IS_PORT 1
`define KEY_PIN 8'hB2
`define KEY_CLEAR 8'h71
`define OSC_RESET 2'h1
`define OSC_DEAD 2'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define RESET_HOLD_NS 100
`define WARMUP_TIME_NS 20000
`define RESET_HOLD_CYC ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARMUP_CYC ((`WARMUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- reset_cause_monitor.sv
// checker of the reset cause block, watching only the top module ports
// assumes the defs header on the include path and short hold and warm-up counts
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_defs.svh"
module reset_cause_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // factors, pin and system reset
  input wire logic volt_detect,
  input wire logic wdt_overflow,
  input wire logic flash_standby,
  input wire logic flash_access,
  input wire logic reset_pin_in,
  input wire logic pin_is_port,
  input wire logic pin_port_value,
  input wire logic trim_fetch_req,
  input wire logic cpu_reset_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // bus answers
  // ----
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (psel && !penable && paddr == 12'h100 |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && paddr == `OFS_CAUSE |=> !pslverr)
    else $error("mapped access refused");
  // ----
  // reset factors
  // ----
  factor_reset_a: assert property (cpu_reset_n && (volt_detect || wdt_overflow) |-> ##2 !cpu_reset_n)
    else $error("factor gave no reset");
  flash_reset_a: assert property (cpu_reset_n && flash_standby && flash_access |-> ##2 !cpu_reset_n)
    else $error("flash standby access gave no reset");
  clock_reset_a: assert property (cpu_reset_n && psel && !penable && pwrite && paddr == `OFS_OSC
    && pwdata[1:0] == 2'h0 |-> ##[2:3] !cpu_reset_n) else $error("dead clock gave no reset");
  // a reset always spans hold plus warm-up, so at least eight cycles here
  hold_len_a: assert property ($fell(cpu_reset_n) |-> !cpu_reset_n [*8])
    else $error("reset shorter than warm-up");
  fetch_in_warm_a: assert property (trim_fetch_req |-> !cpu_reset_n)
    else $error("trim fetch while running");
  ext_reset_a: assert property ((!pin_is_port && !reset_pin_in) [*4] |=> !cpu_reset_n)
    else $error("low reset pin gave no reset");
  port_idle_a: assert property (!pin_is_port && !$past(pin_is_port) |-> pin_port_value)
    else $error("port value not idle high");
  // main scenarios reached
  cover property ($fell(cpu_reset_n));
  cover property (pslverr);
  cover property ($rose(pin_is_port));
endmodule // reset_cause_monitor
bind internal_reset_cause_logic reset_cause_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_detect(volt_detect),
  .wdt_overflow(wdt_overflow), .flash_standby(flash_standby), .flash_access(flash_access),
  .reset_pin_in(reset_pin_in), .pin_is_port(pin_is_port), .pin_port_value(pin_port_value),
  .trim_fetch_req(trim_fetch_req), .cpu_reset_n(cpu_reset_n));
`default_nettype wire

//--- reset_cause_pkg.sv
// types shared by the reset cause block
// assumes nothing of its surroundings
`default_nettype none
package reset_cause_pkg;
  // sequencer phases, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_WARM = 3'b100
  } seq_state_type;
endpackage
`default_nettype wire

//--- tb_internal_reset_cause_logic.sv
// self-checking bench of the reset cause block over apb
// assumes the design, its defs header and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_defs.svh"
module tb_internal_reset_cause_logic;
  logic pclk, presetn, psel, penable, pwrite, pin, par, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, fetch, port, pval, rstn;
  logic [4:0] fac;
  logic [5:0] trim, tval;
  logic [1:0] osc;
  int num_errors, checks, cyc;
  // short hold and warm-up keep every internal reset to a dozen cycles
  internal_reset_cause_logic #(.HOLD_CYC(2), .WARM_CYC(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_detect(fac[0]),
    .wdt_overflow(fac[1]), .flash_standby(fac[4]), .flash_access(fac[4]), .trim_upset(fac[3]),
    .nvm_trim_data(trim), .nvm_trim_par(par), .trim_fetch_req(fetch), .trim_value(tval),
    .reset_pin_in(pin), .pin_is_port(port), .pin_port_value(pval), .cpu_reset_n(rstn), .osc_enable(osc));
  // ----
  // clock and hang guard
  // ----
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  // ----
  // tasks
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one transfer; waits on pready, so any wait state count is taken; only the hang guard ends a wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("prdata", q, e);
  endtask
  // waits out a reset just launched, bounded
  task wrun;
    int n;
    repeat (4) @(posedge pclk);
    n = 0;
    while (rstn !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("cpu_reset_n", 32'(rstn), 1);
  endtask
  task hit(input int i);
    fac[i] <= 1;
    @(posedge pclk);
    fac[i] <= 0;
  endtask
  task end_of_test;
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fac} = 0;
    pin = 1;
    trim = 6'h01;
    par = 1;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    wrun;
    chk("trim_fetch_req", 32'(fetch), 0);
    rd(`OFS_CAUSE, 0);
    rd(`OFS_OSC, 1);
    chk("osc_enable", 32'(osc), 1);
    rd(`OFS_TRIM, 1);
    chk("trim_value", 32'(tval), 1);
    rd(`OFS_KEY, 0);
    rd(12'h100, 0);
    chk("pslverr", 32'(err), 1);
    // each factor alone sets its own flag, then a clear wipes it
    for (int i = 0; i < 5; i++) begin
      if (i == 2) begin
        apb(1, `OFS_OSC, 32'h3);
        rd(`OFS_OSC, 3);
        chk("osc_enable", 32'(osc), 3);
        apb(1, `OFS_OSC, 0);
      end else begin
        hit(i);
      end
      wrun;
      if (i == 2) chk("osc_enable", 32'(osc), 1);
      rd(`OFS_CAUSE, 32'h1 << i);
      apb(1, `OFS_CAUSE, 32'h80);
      apb(1, `OFS_KEY, 32'h71);
      rd(`OFS_CAUSE, 0);
    end
    rd(`OFS_TRIM, 1);
    // bad parity during one fetch only, else the latch would keep resetting
    par <= 0;
    hit(1);
    repeat (4) @(posedge pclk);
    chk("trim_fetch_req", 32'(fetch), 1);
    for (int n = 0; n < 50 && fetch === 1'b1; n++) @(posedge pclk);
    par <= 1;
    wrun;
    apb(0, `OFS_CAUSE, 0);
    chk("trim fault", q & 32'h22, 32'h22);
    apb(1, `OFS_OSC, 0);
    wrun;
    apb(0, `OFS_CAUSE, 0);
    chk("refetch", q & 32'h24, 32'h24);
    // pin low resets while it is a reset pin and wipes the flags
    pin <= 0;
    repeat (6) @(posedge pclk);
    pin <= 1;
    wrun;
    rd(`OFS_CAUSE, 0);
    // reset pin to port and back, each by the key
    apb(1, `OFS_SYSCFG3, 1);
    apb(1, `OFS_KEY, 32'hB2);
    repeat (2) @(posedge pclk);
    chk("pin_is_port", 32'(port), 1);
    rd(`OFS_SYSCFG3, 3);
    pin <= 0;
    repeat (6) @(posedge pclk);
    chk("pin_port_value", 32'(pval), 0);
    chk("cpu_reset_n", 32'(rstn), 1);
    pin <= 1;
    apb(1, `OFS_SYSCFG3, 0);
    apb(1, `OFS_KEY, 32'h71);
    repeat (2) @(posedge pclk);
    chk("pin_is_port", 32'(port), 1);
    apb(1, `OFS_KEY, 32'hB2);
    repeat (2) @(posedge pclk);
    chk("pin_is_port", 32'(port), 0);
    end_of_test;
  end
endmodule // tb_internal_reset_cause_logic
`default_nettype wire
